// file: logic/flash_page_protect_control.sv
// Flash page select, sector write lock and operation timing behind an AXI4-Lite slave.
`timescale 1ns/1ps
// Contract
// - Info select maps information area to FE00H-FFFFH.
// - Seven-bit page forms flash address bits 15:9.
// - Sector lock reachable only after control 5EH.
// - Sector lock bits set only, never cleared.
// - Locked sector blocks program and erase.
// - Sector lock and page select share FF9H.
// - High and low bytes form sixteen-bit kHz value.
module flash_page_protect_control
  import flash_ctrl_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] flashAddr,
  output logic [7:0] flashWriteData,
  output logic flashProgram,
  output logic flashErase,
  output logic infoAreaSelected
);
  // Software-visible state.
  logic [7:0] pageSelect;
  logic [7:0] sectorWriteLock;
  logic [7:0] flashClockKhzHigh;
  logic [7:0] flashClockKhzLow;
  logic [7:0] progData;
  logic [8:0] pageOffset;
  logic unlocked;
  logic violation;
  logic [7:0] next_pageSelect;
  logic [7:0] next_sectorWriteLock;
  logic [7:0] next_flashClockKhzHigh;
  logic [7:0] next_flashClockKhzLow;
  logic [7:0] next_progData;
  logic [8:0] next_pageOffset;
  logic next_unlocked;
  logic next_violation;

  // Bus handshake state.
  logic next_awready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [DATA_W-1:0] next_rdata;

  // Operation state.
  op_state_e opState;
  op_state_e next_opState;
  logic [15:0] msCount;
  logic [15:0] next_msCount;
  logic [15:0] opLength;
  logic [15:0] next_opLength;
  logic [15:0] next_flashAddr;
  logic [7:0] next_flashWriteData;
  logic next_flashProgram;
  logic next_flashErase;
  logic next_infoAreaSelected;

  logic wrTake;
  logic rdTake;
  logic [11:0] wrIdx;
  logic [11:0] rdIdx;
  logic [7:0] wrByte;
  logic wrMapped;
  logic rdMapped;
  logic [15:0] flashClockKhz;
  logic [15:0] targetAddr;
  logic targetLocked;
  logic startProg;
  logic startErase;
  logic msTick;

  assign wrTake = awvalid & awready;
  assign rdTake = arvalid & arready;
  assign wrIdx = awaddr[ADDR_W-1:IDX_LSB];
  assign rdIdx = araddr[ADDR_W-1:IDX_LSB];
  assign wrByte = wdata[7:0];
  assign flashClockKhz = {flashClockKhzHigh, flashClockKhzLow};
  assign wrMapped = (wrIdx >= CTRL_IDX);
  assign rdMapped = (rdIdx >= CTRL_IDX);

  // Target of the next program or erase: information area or the selected page.
  always_comb
  begin
    if (pageSelect[INFO_SEL_BIT])
    begin
      targetAddr = {INFO_PAGE, pageOffset};
    end
    else
    begin
      targetAddr = {pageSelect[6:0], pageOffset};
    end
    targetLocked = sectorWriteLock[targetAddr[SECTOR_MSB:SECTOR_LSB]];
  end

  assign startProg = wrTake && wstrb[0] && wrIdx == CMD_IDX && wrByte[CMD_PROG_BIT] && opState == OP_IDLE;
  assign startErase = wrTake && wstrb[0] && wrIdx == CMD_IDX && wrByte[CMD_ERASE_BIT] && !wrByte[CMD_PROG_BIT]
    && opState == OP_IDLE;

  // Write channel: address and data are taken together, the response follows.
  always_comb
  begin
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (wrTake)
    begin
      next_bvalid = 1'b1;
      next_bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register writes.
  always_comb
  begin
    next_pageSelect = pageSelect;
    next_sectorWriteLock = sectorWriteLock;
    next_flashClockKhzHigh = flashClockKhzHigh;
    next_flashClockKhzLow = flashClockKhzLow;
    next_progData = progData;
    next_pageOffset = pageOffset;
    next_unlocked = unlocked;
    next_violation = violation;
    if (wrTake && wstrb[0])
    begin
      unique case (wrIdx)
        CTRL_IDX:
        begin
          next_unlocked = (wrByte == UNLOCK_CODE);
          next_violation = 1'b0;
        end
        PROT_IDX:
        begin
          if (unlocked)
          begin
            next_sectorWriteLock = sectorWriteLock | wrByte;
          end
          else
          begin
            next_pageSelect = wrByte;
          end
        end
        FREQ_HI_IDX: next_flashClockKhzHigh = wrByte;
        FREQ_LO_IDX: next_flashClockKhzLow = wrByte;
        DATA_IDX: next_progData = wrByte;
        OFFS_HI_IDX: next_pageOffset = {wrByte[0], pageOffset[7:0]};
        OFFS_LO_IDX: next_pageOffset = {pageOffset[8], wrByte};
        default:
        begin
          next_unlocked = unlocked;
        end
      endcase
    end
    // A blocked start sets the flag even in the cycle it would be cleared.
    if ((startProg || startErase) && targetLocked)
    begin
      next_violation = 1'b1;
    end
  end

  // Read channel.
  always_comb
  begin
    next_arready = arvalid && !arready && !rvalid;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
    if (rdTake)
    begin
      next_rvalid = 1'b1;
      next_rresp = rdMapped ? RESP_OKAY : RESP_SLVERR;
      next_rdata = '0;
      unique case (rdIdx)
        CTRL_IDX:
        begin
          next_rdata[STAT_BUSY_BIT] = (opState == OP_RUN);
          next_rdata[STAT_VIOL_BIT] = violation;
          next_rdata[STAT_UNLOCK_BIT] = unlocked;
        end
        PROT_IDX: next_rdata[7:0] = unlocked ? sectorWriteLock : pageSelect;
        FREQ_HI_IDX: next_rdata[7:0] = flashClockKhzHigh;
        FREQ_LO_IDX: next_rdata[7:0] = flashClockKhzLow;
        DATA_IDX: next_rdata[7:0] = progData;
        OFFS_HI_IDX: next_rdata[0] = pageOffset[8];
        OFFS_LO_IDX: next_rdata[7:0] = pageOffset[7:0];
        default: next_rdata = '0;
      endcase
    end
  end

  // Program and erase sequencer, timed in milliseconds of the kHz value.
  always_comb
  begin
    next_opState = opState;
    next_msCount = msCount;
    next_opLength = opLength;
    next_flashAddr = flashAddr;
    next_flashWriteData = flashWriteData;
    next_flashProgram = flashProgram;
    next_flashErase = flashErase;
    next_infoAreaSelected = pageSelect[INFO_SEL_BIT];
    unique case (opState)
      OP_IDLE:
      begin
        if ((startProg || startErase) && !targetLocked)
        begin
          next_opState = OP_RUN;
          next_msCount = '0;
          next_opLength = startProg ? PROG_MS : ERASE_MS;
          next_flashAddr = startProg ? targetAddr : {targetAddr[15:9], 9'h000};
          next_flashWriteData = progData;
          next_flashProgram = startProg;
          next_flashErase = startErase;
        end
      end
      OP_RUN:
      begin
        if (msTick)
        begin
          next_msCount = msCount + 16'h0001;
          if (msCount + 16'h0001 >= opLength)
          begin
            next_opState = OP_IDLE;
            next_flashProgram = 1'b0;
            next_flashErase = 1'b0;
          end
        end
      end
    endcase
  end

  ms_tick_divider #(
    .WIDTH(16)
  ) u_ms_tick (
    .clk(clk),
    .srst(srst),
    .run(opState == OP_RUN),
    .divisor(flashClockKhz),
    .tick(msTick)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pageSelect <= PAGE_RESET;
      sectorWriteLock <= LOCK_RESET;
      flashClockKhzHigh <= FREQ_RESET;
      flashClockKhzLow <= FREQ_RESET;
      progData <= 8'h00;
      pageOffset <= 9'h000;
      unlocked <= 1'b0;
      violation <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      opState <= OP_IDLE;
      msCount <= 16'h0000;
      opLength <= 16'h0000;
      flashAddr <= 16'h0000;
      flashWriteData <= 8'h00;
      flashProgram <= 1'b0;
      flashErase <= 1'b0;
      infoAreaSelected <= 1'b0;
    end
    else
    begin
      pageSelect <= next_pageSelect;
      sectorWriteLock <= next_sectorWriteLock;
      flashClockKhzHigh <= next_flashClockKhzHigh;
      flashClockKhzLow <= next_flashClockKhzLow;
      progData <= next_progData;
      pageOffset <= next_pageOffset;
      unlocked <= next_unlocked;
      violation <= next_violation;
      awready <= next_awready;
      wready <= next_awready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      opState <= next_opState;
      msCount <= next_msCount;
      opLength <= next_opLength;
      flashAddr <= next_flashAddr;
      flashWriteData <= next_flashWriteData;
      flashProgram <= next_flashProgram;
      flashErase <= next_flashErase;
      infoAreaSelected <= next_infoAreaSelected;
    end
  end
endmodule

// file: logic/flash_ctrl_pkg.sv
// Constants shared by the flash page, protection and timing control logic.
package flash_ctrl_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] CTRL_IDX = 12'hFF8;
  localparam logic [11:0] PROT_IDX = 12'hFF9;
  localparam logic [11:0] FREQ_HI_IDX = 12'hFFA;
  localparam logic [11:0] FREQ_LO_IDX = 12'hFFB;
  localparam logic [11:0] CMD_IDX = 12'hFFC;
  localparam logic [11:0] DATA_IDX = 12'hFFD;
  localparam logic [11:0] OFFS_HI_IDX = 12'hFFE;
  localparam logic [11:0] OFFS_LO_IDX = 12'hFFF;
  localparam int ADDR_W = 14;
  localparam int IDX_LSB = 2;

  // Control values and field positions.
  localparam logic [7:0] UNLOCK_CODE = 8'h5E;
  localparam int INFO_SEL_BIT = 7;
  localparam int CMD_PROG_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VIOL_BIT = 1;
  localparam int STAT_UNLOCK_BIT = 2;
  localparam int SECTOR_MSB = 15;
  localparam int SECTOR_LSB = 13;

  // Information area sits at FE00H..FFFFH, that is page 7FH.
  localparam logic [6:0] INFO_PAGE = 7'h7F;

  // Reset values.
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'h00;

  // Operation lengths in milliseconds, counted in ticks of flash_clock_khz cycles.
  localparam logic [15:0] PROG_MS = 16'h0001;
  localparam logic [15:0] ERASE_MS = 16'h000A;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {OP_IDLE, OP_RUN} op_state_e;
endpackage

// file: logic/ms_tick_divider.sv
// Divider that pulses once every flash_clock_khz system clocks, i.e. once per millisecond.
`timescale 1ns/1ps
module ms_tick_divider #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (!run)
    begin
      next_count = '0;
    end
    else if (count + 1'b1 >= divisor)
    begin
      // A divisor of zero or one still yields one tick per cycle.
      next_count = '0;
      next_tick = 1'b1;
    end
    else
    begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// file: bench/flash_ctrl_monitor.sv
// Bus handshake and flash output checker for the flash control block.
`timescale 1ns/1ps
module flash_ctrl_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [15:0] flashAddr,
  input wire logic flashProgram,
  input wire logic flashErase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wtake;
    awready ##1 bvalid;
  endsequence
  property p_wtake; awready |-> s_wtake; endproperty
  property p_wpair; awready == wready; endproperty
  property p_apulse; awready |=> !awready; endproperty
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rtake; arready |=> rvalid; endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_excl; !(flashProgram && flashErase); endproperty
  property p_page; flashErase |-> flashAddr[8:0] == 9'h000; endproperty
  property p_hold; flashProgram |=> !flashProgram || $stable(flashAddr); endproperty
  a_wtake: assert property (p_wtake) else $error("no write answer");
  a_wpair: assert property (p_wpair) else $error("ready split");
  a_apulse: assert property (p_apulse) else $error("awready long");
  a_bhold: assert property (p_bhold) else $error("bresp moved");
  a_rtake: assert property (p_rtake) else $error("no read answer");
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  a_excl: assert property (p_excl) else $error("two ops");
  a_page: assert property (p_page) else $error("erase not page");
  a_hold: assert property (p_hold) else $error("address moved");
endmodule
bind flash_page_protect_control flash_ctrl_monitor u_mon (.clk, .srst, .awready, .wready, .bresp, .bvalid,
  .bready, .arready, .rdata, .rvalid, .rready, .flashAddr, .flashProgram, .flashErase);

// file: bench/flash_page_protect_control_bench.sv
// Register-level regression of the flash page, lock and timing block.
`timescale 1ns/1ps
module flash_page_protect_control_bench;
  import flash_ctrl_pkg::*;
  logic clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [13:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, flashProgram, flashErase, infoAreaSelected;
  logic [1:0] bresp, rresp;
  logic [15:0] flashAddr;
  logic [7:0] flashWriteData;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;

  flash_page_protect_control u_dut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .flashAddr, .flashWriteData, .flashProgram, .flashErase, .infoAreaSelected);

  initial forever #2 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The whole run needs about 3500 cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("[ERR] %0t timeout before the last test ended", $time);
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, r);
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h000000, d});
    chk(rresp, r);
  endtask

  // Counts the cycles of the running operation from its first visible cycle.
  task automatic dur(input int lo);
    int k;
    k = 1;
    while ((flashProgram | flashErase) === 1'b1)
    begin
      @(posedge clk);
      k++;
    end
    chk(k >= lo && k <= lo + 4, 1);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(PROT_IDX, 8'h00, RESP_OKAY);
    wr(PROT_IDX, 8'h85, RESP_OKAY);
    rd(PROT_IDX, 8'h85, RESP_OKAY);
    chk(infoAreaSelected, 1);
    $display("select test done");
    wr(CTRL_IDX, UNLOCK_CODE, RESP_OKAY);
    rd(CTRL_IDX, 8'h04, RESP_OKAY);
    rd(PROT_IDX, 8'h00, RESP_OKAY);
    wr(PROT_IDX, 8'h03, RESP_OKAY);
    wr(PROT_IDX, 8'h00, RESP_OKAY);
    rd(PROT_IDX, 8'h03, RESP_OKAY);
    wr(CTRL_IDX, 8'h5F, RESP_OKAY);
    rd(PROT_IDX, 8'h85, RESP_OKAY);
    $display("lock test done");
    wr(PROT_IDX, 8'h20, RESP_OKAY);
    // The value 0103H names a 259 kHz clock, inside the range that supports program and erase.
    wr(FREQ_HI_IDX, 8'h01, RESP_OKAY);
    wr(FREQ_LO_IDX, 8'h03, RESP_OKAY);
    rd(FREQ_HI_IDX, 8'h01, RESP_OKAY);
    wr(OFFS_HI_IDX, 8'h01, RESP_OKAY);
    wr(OFFS_LO_IDX, 8'h10, RESP_OKAY);
    wr(DATA_IDX, 8'hA5, RESP_OKAY);
    wr(CMD_IDX, 8'h01, RESP_OKAY);
    chk(flashProgram, 1);
    chk(flashAddr, 16'h4110);
    chk(flashWriteData, 8'hA5);
    chk(infoAreaSelected, 0);
    dur(259);
    $display("program test done");
    wr(PROT_IDX, 8'h05, RESP_OKAY);
    wr(CMD_IDX, 8'h02, RESP_OKAY);
    chk(flashErase, 0);
    rd(CTRL_IDX, 8'h02, RESP_OKAY);
    $display("blocked test done");
    wr(PROT_IDX, 8'h80, RESP_OKAY);
    wr(CMD_IDX, 8'h02, RESP_OKAY);
    chk(flashErase, 1);
    chk(flashAddr, 16'hFE00);
    dur(2590);
    // Both command bits set: program wins and targets the information area.
    wr(CMD_IDX, 8'h03, RESP_OKAY);
    chk(flashErase, 0);
    chk(flashAddr, 16'hFF10);
    dur(259);
    rd(CMD_IDX, 8'h00, RESP_OKAY);
    rd(DATA_IDX, 8'hA5, RESP_OKAY);
    rd(OFFS_HI_IDX, 8'h01, RESP_OKAY);
    $display("info erase test done");
    wr(12'h000, 8'h11, RESP_SLVERR);
    rd(12'h000, 8'h00, RESP_SLVERR);
    $display("unmapped test done");
    give_verdict;
  end
endmodule
